/* rtl/vector_issue_scoreboard.sv */
// Vector issue unit with register scoreboard, load/store and arithmetic units.
`timescale 1ns/1ns
`include "vector_issue_consts.svh"
module vector_issue_scoreboard #(
  parameter int NREGS = `VREG_COUNT,
  parameter int PIPES = `PIPE_COUNT,
  parameter logic [7:0] FIXED_COST = `FIXED_COST_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input vector_issue_pkg::vinstr_t instr,
  output logic instr_ready,
  input wire logic mem_mgmt_ok_ack,
  output logic scalar_stall,
  output logic [6:0] element_count_reg,
  output vector_issue_pkg::ls_req_t ls_req,
  output logic arith_result_valid,
  output logic [3:0] arith_result_reg,
  output logic fpu_active,
  output logic ls_busy
);
  import vector_issue_pkg::*;
  initial begin
    if (NREGS != 16) $error("register fields are four bits; NREGS must be 16");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  function automatic logic is_mem(input logic [3:0] op);
    return op == `OP_LOAD || op == `OP_STORE || op == `OP_GATHER || op == `OP_SCATTER;
  endfunction : is_mem

  function automatic logic is_read_mem(input logic [3:0] op);
    return op == `OP_LOAD || op == `OP_GATHER;
  endfunction : is_read_mem

  function automatic logic [NREGS-1:0] bit_of(input logic [3:0] r);
    return NREGS'(1) << r;
  endfunction : bit_of

  //////////////////////////////////////////////////////////////////////////////
  // State.

  logic [6:0] len_ff;
  logic mem_mgmt_ok_ack_wait_ff;
  logic [NREGS-1:0] pend_ff;
  logic mask_pend_ff;
  logic [NREGS-1:0] defer_use;
  logic [NREGS-1:0] exec_dst_bit;
  logic [NREGS-1:0] defer_dst_bit;
  logic hazard;
  logic unit_free;
  logic do_issue;
  logic arith_issue;
  logic mem_issue;
  logic len_load;
  logic defer_full;
  logic exec_valid;
  logic [3:0] exec_dst;
  logic exec_chain;
  logic defer_valid;
  arith_op_t defer_op;
  arith_op_t issue_op;
  logic done_pulse;
  logic [3:0] done_reg;
  logic ls_pipe_busy;

  //////////////////////////////////////////////////////////////////////////////
  // Scoreboard views of the arithmetic unit.

  assign exec_dst_bit = exec_valid ? bit_of(exec_dst) : '0;
  assign defer_dst_bit = defer_valid ? bit_of(defer_op.dst) : '0;
  assign defer_use = defer_valid ?
      (bit_of(defer_op.dst) | bit_of(defer_op.src_a) | bit_of(defer_op.src_b)) : '0;

  always_comb begin
    hazard = 1'b0;
    unique case (instr.opcode)
      `OP_LOAD, `OP_GATHER: begin
        // Load target must not be written now or touched by the deferred one.
        hazard = (exec_dst_bit[instr.dst] | defer_use[instr.dst]);
      end
      `OP_STORE, `OP_SCATTER: begin
        // A store reading a chainable executing result may go ahead.
        hazard = defer_dst_bit[instr.src_a]
            | (exec_dst_bit[instr.src_a] & !exec_chain);
      end
      default: hazard = 1'b0;
    endcase
    if (instr.opcode == `OP_GATHER || instr.opcode == `OP_SCATTER)
      hazard = hazard | exec_dst_bit[instr.offs] | defer_dst_bit[instr.offs];
    if (is_mem(instr.opcode) && instr.masked)
      hazard = hazard | mask_pend_ff;
    if (is_mem(instr.opcode) && pend_ff[instr.dst] && is_read_mem(instr.opcode))
      hazard = 1'b1;
  end

  // Arithmetic waits only for the deferred slot; memory never waits for a unit.
  assign unit_free = is_mem(instr.opcode) ? 1'b1 : !defer_full;
  assign len_load = instr.opcode == `OP_SETLEN;
  assign instr_ready = !mem_mgmt_ok_ack_wait_ff && (len_load || (unit_free && !hazard));
  assign do_issue = instr_valid && instr_ready;
  assign mem_issue = do_issue && is_mem(instr.opcode);
  assign arith_issue = do_issue && !is_mem(instr.opcode) && !len_load;
  assign scalar_stall = mem_mgmt_ok_ack_wait_ff;

  assign issue_op = '{opcode: instr.opcode, dst: instr.dst, src_a: instr.src_a,
                      src_b: instr.src_b, single_prec: instr.single_prec,
                      vector_len: len_ff};

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk) begin
    if (!rst_n) len_ff <= `VLEN_RESET;
    else if (do_issue && len_load) len_ff <= instr.new_len;
  end

  // The acknowledge in the issue cycle itself does not count: it belongs to
  // nothing yet, so the wait always ends on a later okay.
  always_ff @(posedge clk) begin
    if (!rst_n) mem_mgmt_ok_ack_wait_ff <= 1'b0;
    else if (mem_issue) mem_mgmt_ok_ack_wait_ff <= 1'b1;
    else if (mem_mgmt_ok_ack) mem_mgmt_ok_ack_wait_ff <= 1'b0;
  end

  // Pending writes: set on arithmetic issue, cleared after the final element.
  // A new set to the same register wins over the clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~(done_pulse ? bit_of(done_reg) : '0))
          | (arith_issue ? bit_of(instr.dst) : '0);
    end
  end

  // Compare instructions write the mask register.
  always_ff @(posedge clk) begin
    if (!rst_n) mask_pend_ff <= 1'b0;
    else if (arith_issue && instr.opcode == `OP_CMP) mask_pend_ff <= 1'b1;
    else if (!exec_valid && !defer_valid) mask_pend_ff <= 1'b0;
  end

  assign element_count_reg = len_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Function units.

  ls_pipe #(
    .STAGES(`LS_STAGES)
  ) u_ls (
    .clk(clk),
    .rst_n(rst_n),
    .start(mem_issue),
    .start_store(!is_read_mem(instr.opcode)),
    .start_reg(is_read_mem(instr.opcode) ? instr.dst : instr.src_a),
    .start_pair(instr.opcode == `OP_LOAD && instr.single_prec && instr.unit_stride),
    .start_len(len_ff),
    .req_out(ls_req),
    .busy(ls_pipe_busy)
  );

  arith_unit #(
    .PIPES(PIPES),
    .FIXED_COST(FIXED_COST)
  ) u_arith (
    .clk(clk),
    .rst_n(rst_n),
    .issue(arith_issue),
    .issue_op(issue_op),
    .deferred_full(defer_full),
    .exec_valid(exec_valid),
    .exec_dst(exec_dst),
    .exec_chainable(exec_chain),
    .defer_valid(defer_valid),
    .defer_op(defer_op),
    .result_valid(arith_result_valid),
    .result_reg(arith_result_reg),
    .done_pulse(done_pulse),
    .done_reg(done_reg),
    .to_fpu(fpu_active)
  );

  assign ls_busy = ls_pipe_busy;
endmodule : vector_issue_scoreboard

/* rtl/vector_issue_consts.svh */
// Constants for the vector issue and scoreboard block.
`ifndef VECTOR_ISSUE_CONSTS_SVH
`define VECTOR_ISSUE_CONSTS_SVH
`define VREG_COUNT 16
`define VLEN_W 7
`define VLEN_RESET 7'h40
`define LS_STAGES 5
`define PIPE_COUNT 4
`define MIN_OVERLAP_LEN 7'h08
`define RESULT_GAP 1
`define FIXED_COST_DEFAULT 8'h06
`define DIV_ELEM_COST 4'h8
`define SP_ELEM_COST 4'h1
`define DP_ELEM_COST 4'h2
`define OP_LOAD 4'h0
`define OP_STORE 4'h1
`define OP_GATHER 4'h2
`define OP_SCATTER 4'h3
`define OP_FP 4'h4
`define OP_CMP 4'h5
`define OP_SHIFT 4'h6
`define OP_IMUL 4'h7
`define OP_BOOL 4'h8
`define OP_MERGE 4'h9
`define OP_DIV 4'hA
`define OP_SETLEN 4'hB
`endif

/* rtl/vector_issue_pkg.sv */
// Types shared by the vector issue unit and its sub-blocks.
package vector_issue_pkg;
  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] dst;
    logic [3:0] src_a;
    logic [3:0] src_b;
    logic [3:0] offs;
    logic masked;
    logic single_prec;
    logic unit_stride;
    logic [6:0] new_len;
  } vinstr_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] dst;
    logic [3:0] src_a;
    logic [3:0] src_b;
    logic single_prec;
    logic [6:0] vector_len;
  } arith_op_t;

  typedef struct packed {
    logic valid;
    logic is_store;
    logic [3:0] reg_idx;
    logic [6:0] elem_idx;
    logic paired;
  } ls_req_t;
endpackage : vector_issue_pkg

/* rtl/ls_pipe.sv */
// Five-stage load/store element pipeline.
`timescale 1ns/1ns
`include "vector_issue_consts.svh"
module ls_pipe #(
  parameter int STAGES = `LS_STAGES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic start_store,
  input wire logic [3:0] start_reg,
  input wire logic start_pair,
  input wire logic [6:0] start_len,
  output vector_issue_pkg::ls_req_t req_out,
  output logic busy
);
  import vector_issue_pkg::*;
  initial begin
    if (STAGES < 1) $error("ls_pipe needs at least one stage");
  end

  ls_req_t stage_ff [STAGES];
  logic [6:0] elem_ff;
  logic [6:0] len_ff;
  logic store_ff;
  logic pair_ff;
  logic [3:0] reg_ff;
  logic active_ff;
  logic [6:0] step;
  logic any_stage;

  // A pair of single-precision unit-stride load elements moves as one request.
  assign step = pair_ff ? 7'h02 : 7'h01;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_ff <= 1'b0;
      elem_ff <= 7'h00;
      len_ff <= 7'h00;
      store_ff <= 1'b0;
      pair_ff <= 1'b0;
      reg_ff <= 4'h0;
    end else if (start) begin
      active_ff <= (start_len != 7'h00);
      elem_ff <= 7'h00;
      len_ff <= start_len;
      store_ff <= start_store;
      pair_ff <= start_pair;
      reg_ff <= start_reg;
    end else if (active_ff) begin
      if ({1'b0, elem_ff} + {1'b0, step} >= {1'b0, len_ff}) active_ff <= 1'b0;
      elem_ff <= elem_ff + step;
    end
  end

  // One request enters per cycle and marches down the stages.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) stage_ff[i] <= '0;
    end else begin
      stage_ff[0] <= '{valid: active_ff, is_store: store_ff, reg_idx: reg_ff,
                       elem_idx: elem_ff, paired: pair_ff};
      for (int i = 1; i < STAGES; i++) stage_ff[i] <= stage_ff[i-1];
    end
  end

  always_comb begin
    any_stage = 1'b0;
    for (int i = 0; i < STAGES; i++) any_stage = any_stage | stage_ff[i].valid;
  end

  assign req_out = stage_ff[STAGES-1];
  assign busy = active_ff | any_stage;
endmodule : ls_pipe

/* rtl/arith_unit.sv */
// Arithmetic unit sequencer: one executing and one deferred instruction.
`timescale 1ns/1ns
`include "vector_issue_consts.svh"
module arith_unit #(
  parameter int PIPES = `PIPE_COUNT,
  parameter logic [7:0] FIXED_COST = `FIXED_COST_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue,
  input vector_issue_pkg::arith_op_t issue_op,
  output logic deferred_full,
  output logic exec_valid,
  output logic [3:0] exec_dst,
  output logic exec_chainable,
  output logic defer_valid,
  output vector_issue_pkg::arith_op_t defer_op,
  output logic result_valid,
  output logic [3:0] result_reg,
  output logic done_pulse,
  output logic [3:0] done_reg,
  output logic to_fpu
);
  import vector_issue_pkg::*;
  initial begin
    if (PIPES < 1 || PIPES > 8) $error("arith_unit supports 1 to 8 pipelines");
  end

  arith_op_t cur_ff;
  arith_op_t def_ff;
  logic cur_v_ff;
  logic def_v_ff;
  logic [7:0] startup_ff;
  logic [3:0] pace_ff;
  logic [7:0] groups_ff;
  logic started_ff;
  logic promote;
  logic last_res;

  function automatic logic uses_fpu(input logic [3:0] op);
    return op == `OP_FP || op == `OP_CMP || op == `OP_SHIFT || op == `OP_IMUL
        || op == `OP_DIV;
  endfunction : uses_fpu

  function automatic logic [3:0] elem_cost(input arith_op_t op);
    if (op.opcode == `OP_DIV) return `DIV_ELEM_COST;
    return op.single_prec ? `SP_ELEM_COST : `DP_ELEM_COST;
  endfunction : elem_cost

  // Result groups are ceil(len / pipes); each group costs elem_cost cycles.
  function automatic logic [7:0] group_count(input logic [6:0] len);
    return 8'((int'(len) + PIPES - 1) / PIPES);
  endfunction : group_count

  // A zero-length op must still end, or its pending-write mark would never clear.
  assign last_res = cur_v_ff && started_ff && pace_ff == 4'h1 && groups_ff <= 8'h01;
  assign result_valid = cur_v_ff && started_ff && pace_ff == 4'h1;
  assign result_reg = cur_ff.dst;

  // Early start needs both on the FPU, no divide, and a long enough vector.
  // The new instruction still starts after the last result, one cycle of gap,
  // so it never outputs before the current one completes.
  always_comb begin
    promote = 1'b0;
    if (def_v_ff && (!cur_v_ff || last_res)) promote = 1'b1;
  end

  assign deferred_full = def_v_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_v_ff <= 1'b0;
      cur_ff <= '0;
      startup_ff <= 8'h00;
      pace_ff <= 4'h0;
      groups_ff <= 8'h00;
      started_ff <= 1'b0;
    end else if (promote || (issue && !cur_v_ff && !def_v_ff)) begin
      cur_v_ff <= 1'b1;
      cur_ff <= promote ? def_ff : issue_op;
      // An overlapped follower sees a one-cycle startup.
      if (promote && cur_v_ff && uses_fpu(cur_ff.opcode) && uses_fpu(def_ff.opcode)
          && cur_ff.opcode != `OP_DIV && def_ff.opcode != `OP_DIV
          && def_ff.vector_len >= `MIN_OVERLAP_LEN)
        startup_ff <= 8'(`RESULT_GAP);
      else
        startup_ff <= FIXED_COST;
      started_ff <= 1'b0;
      pace_ff <= elem_cost(promote ? def_ff : issue_op);
      groups_ff <= group_count(promote ? def_ff.vector_len : issue_op.vector_len);
    end else if (cur_v_ff) begin
      if (!started_ff) begin
        if (startup_ff <= 8'h01) started_ff <= 1'b1;
        else startup_ff <= startup_ff - 8'h01;
      end else if (pace_ff == 4'h1) begin
        if (groups_ff <= 8'h01) cur_v_ff <= 1'b0;
        groups_ff <= groups_ff - 8'h01;
        pace_ff <= elem_cost(cur_ff);
      end else begin
        pace_ff <= pace_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      def_v_ff <= 1'b0;
      def_ff <= '0;
    end else if (issue && (cur_v_ff || def_v_ff) && !promote) begin
      def_v_ff <= 1'b1;
      def_ff <= issue_op;
    end else if (promote) begin
      def_v_ff <= issue;
      def_ff <= issue ? issue_op : def_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_pulse <= 1'b0;
      done_reg <= 4'h0;
    end else begin
      done_pulse <= last_res;
      done_reg <= cur_ff.dst;
    end
  end

  assign exec_valid = cur_v_ff;
  assign exec_dst = cur_ff.dst;
  assign exec_chainable = cur_v_ff && cur_ff.opcode != `OP_DIV;
  assign defer_valid = def_v_ff;
  assign defer_op = def_ff;
  assign to_fpu = cur_v_ff && uses_fpu(cur_ff.opcode);
endmodule : arith_unit

/* tb/scalar_host.sv */
// Scalar processor model that offers vector instructions to the issue unit.
`timescale 1ns/1ns
module scalar_host
  import vector_issue_pkg::*;
(
  input wire logic clk,
  input wire logic instr_ready,
  input wire logic scalar_stall,
  output logic instr_valid,
  output vector_issue_pkg::vinstr_t instr,
  output logic mem_mgmt_ok_ack
);
  initial begin
    instr_valid = 1'b0;
    instr = '1;
    mem_mgmt_ok_ack = 1'b0;
  end

  // Called at a falling edge; hold keeps valid up so the next call can follow back to back.
  task automatic send(input vinstr_t op, input logic hold, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    while (scalar_stall === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    instr_valid = 1'b1;
    instr = op;
    while (!ok && n < 400) begin
      #1;
      ok = (instr_ready === 1'b1);
      @(posedge clk);
      n++;
      @(negedge clk);
    end
    if (!hold) begin
      // A released bus shows the inverse so stale values are never mistaken for data.
      instr_valid = 1'b0;
      instr = ~op;
    end
  endtask : send

  task automatic ack_after(input int gap);
    repeat (gap) @(negedge clk);
    mem_mgmt_ok_ack = 1'b1;
    @(negedge clk);
    mem_mgmt_ok_ack = 1'b0;
  endtask : ack_after
endmodule : scalar_host

/* tb/vector_issue_scoreboard_asserts.sv */
// Port assertions for the vector issue scoreboard.
`timescale 1ns/1ns
`include "vector_issue_consts.svh"
module vector_issue_scoreboard_asserts
  import vector_issue_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input vector_issue_pkg::vinstr_t instr,
  input wire logic instr_ready,
  input wire logic mem_mgmt_ok_ack,
  input wire logic scalar_stall,
  input wire logic [6:0] element_count_reg,
  input vector_issue_pkg::ls_req_t ls_req,
  input wire logic arith_result_valid,
  input wire logic [3:0] arith_result_reg,
  input wire logic fpu_active,
  input wire logic ls_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence mem_issue_s;
    instr_valid && instr_ready && instr.opcode <= `OP_SCATTER;
  endsequence
  sequence len_issue_s;
    instr_valid && instr_ready && instr.opcode == `OP_SETLEN;
  endsequence
  sequence pair_step_s;
    ls_req.valid && ls_req.paired ##1 ls_req.valid && ls_req.elem_idx != 7'h00;
  endsequence
  a_stall_after_mem: assert property (mem_issue_s |=> scalar_stall)
    else $error("no stall after memory issue");
  a_no_issue_stalled: assert property (scalar_stall |-> !instr_ready)
    else $error("ready while waiting for okay");
  a_stall_release: assert property (scalar_stall && mem_mgmt_ok_ack |=> !scalar_stall)
    else $error("stall kept after okay");
  a_stall_keeps: assert property (scalar_stall && !mem_mgmt_ok_ack |=> scalar_stall)
    else $error("stall dropped without okay");
  a_len_load: assert property (len_issue_s |=> element_count_reg == $past(instr.new_len))
    else $error("length not loaded");
  a_len_keeps: assert property
    (!(instr_valid && instr_ready && instr.opcode == `OP_SETLEN) |=> $stable(element_count_reg))
    else $error("length changed without reload");
  a_ls_follows: assert property (mem_issue_s |-> ##[5:7] ls_req.valid)
    else $error("no element request after memory issue");
  a_pair_step: assert property
    (pair_step_s |-> ls_req.elem_idx == $past(ls_req.elem_idx) + 7'h02)
    else $error("paired request did not step by two");
  a_load_hazard: assert property
    (instr_valid && instr.opcode == `OP_LOAD && arith_result_valid
      && arith_result_reg == instr.dst |-> !instr_ready)
    else $error("load ready against executing write");
endmodule : vector_issue_scoreboard_asserts

bind vector_issue_scoreboard vector_issue_scoreboard_asserts chk (
  .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
  .instr_ready(instr_ready), .mem_mgmt_ok_ack(mem_mgmt_ok_ack), .scalar_stall(scalar_stall),
  .element_count_reg(element_count_reg), .ls_req(ls_req),
  .arith_result_valid(arith_result_valid), .arith_result_reg(arith_result_reg),
  .fpu_active(fpu_active), .ls_busy(ls_busy)
);

/* tb/tb_vector_issue_scoreboard.sv */
// Self-checking testbench for the vector issue scoreboard.
`timescale 1ns/1ns
`include "vector_issue_consts.svh"
module tb_vector_issue_scoreboard;
  import vector_issue_pkg::*;
  logic clk;
  logic rst_n;
  logic instr_valid;
  logic instr_ready;
  logic mem_mgmt_ok_ack;
  logic scalar_stall;
  logic arith_result_valid;
  logic fpu_active;
  logic ls_busy;
  logic [3:0] arith_result_reg;
  logic [6:0] element_count_reg;
  vinstr_t instr;
  ls_req_t ls_req;
  int err_total;
  int checked;
  int cyc;
  int ls_cnt;
  int res_cnt [16];
  int first_cyc [16];
  int last_cyc [16];

  vector_issue_scoreboard dut (
    .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .mem_mgmt_ok_ack(mem_mgmt_ok_ack), .scalar_stall(scalar_stall),
    .element_count_reg(element_count_reg), .ls_req(ls_req),
    .arith_result_valid(arith_result_valid), .arith_result_reg(arith_result_reg),
    .fpu_active(fpu_active), .ls_busy(ls_busy)
  );
  scalar_host host (
    .clk(clk), .instr_ready(instr_ready), .scalar_stall(scalar_stall),
    .instr_valid(instr_valid), .instr(instr), .mem_mgmt_ok_ack(mem_mgmt_ok_ack)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (ls_req.valid === 1'b1) ls_cnt++;
    if (arith_result_valid === 1'b1) begin
      if (res_cnt[arith_result_reg] == 0) first_cyc[arith_result_reg] = cyc;
      last_cyc[arith_result_reg] = cyc;
      res_cnt[arith_result_reg]++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic clear_mon;
    ls_cnt = 0;
    foreach (res_cnt[i]) res_cnt[i] = 0;
  endtask : clear_mon

  function automatic vinstr_t mk(input logic [3:0] opc, input logic [3:0] d,
                                 input logic sp, input logic us, input logic [6:0] len);
    return {opc, d, 4'h1, 4'h1, 4'hE, 1'b0, sp, us, len};
  endfunction : mk

  task automatic issue(input vinstr_t op, input logic hold);
    logic ok;
    host.send(op, hold, ok);
    check(ok, 1'b1);
    if (ok !== 1'b1) wrap_up();
  endtask : issue

  // Waits for a quiet spell long enough to cover the arithmetic startup delay.
  task automatic drain;
    int q;
    q = 0;
    for (int n = 0; n < 400 && q < 12; n++) begin
      @(negedge clk);
      q = (ls_busy === 1'b0 && arith_result_valid === 1'b0 && fpu_active === 1'b0) ? q + 1 : 0;
    end
    check(q, 12);
    if (q < 12) wrap_up();
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////////
  // Offers an arithmetic op and then a memory op that may depend on it, and checks how
  // many results the arithmetic op had returned by the time the memory op was taken.
  task automatic dep_pair(input vinstr_t a, input vinstr_t m, input int exp_res);
    clear_mon();
    issue(a, 1'b1);
    issue(m, 1'b0);
    check(res_cnt[a.dst], exp_res);
    host.ack_after(1);
    drain();
  endtask : dep_pair

  task automatic t_reset_values;
    check(element_count_reg, `VLEN_RESET);
    check(scalar_stall, 1'b0);
    check(ls_req, '0);
    check(instr_ready, 1'b1);
  endtask : t_reset_values

  task automatic t_set_length;
    issue(mk(`OP_SETLEN, 4'h0, 1'b0, 1'b0, 7'h7F), 1'b1);
    check(element_count_reg, 7'h7F);
    issue(mk(`OP_SETLEN, 4'h0, 1'b0, 1'b0, 7'h10), 1'b0);
    check(element_count_reg, 7'h10);
    // Let an edge pass so the valid just dropped is not raised again in the same step.
    @(negedge clk);
  endtask : t_set_length

  task automatic t_mem_ops;
    for (int k = 0; k < 6; k++) begin
      clear_mon();
      issue(mk(4'(`OP_LOAD + k % 4), 4'h2, k > 3, k > 3, 7'h10), 1'b0);
      check(scalar_stall, 1'b1);
      repeat (3) begin
        @(negedge clk);
        check(instr_ready, 1'b0);
      end
      host.ack_after(1);
      check(scalar_stall, 1'b0);
      drain();
      check(ls_cnt, k == 4 ? 8 : 16);
    end
  endtask : t_mem_ops

  task automatic t_load_hazard;
    clear_mon();
    issue(mk(`OP_FP, 4'h3, 1'b1, 1'b0, 7'h10), 1'b1);
    issue(mk(`OP_LOAD, 4'h3, 1'b0, 1'b0, 7'h10), 1'b0);
    check(res_cnt[3], 4);
    host.ack_after(1);
    drain();
  endtask : t_load_hazard

  task automatic t_mem_hazards;
    vinstr_t m;
    m = mk(`OP_STORE, 4'h0, 1'b0, 1'b0, 7'h10);
    dep_pair(mk(`OP_FP, 4'hC, 1'b1, 1'b0, 7'h10), m, 0);
    m.src_a = 4'hC;
    dep_pair(mk(`OP_FP, 4'hC, 1'b1, 1'b0, 7'h10), m, 0);
    m.src_a = 4'hD;
    dep_pair(mk(`OP_DIV, 4'hD, 1'b1, 1'b0, 7'h10), m, 4);
    m = mk(`OP_GATHER, 4'h4, 1'b0, 1'b0, 7'h10);
    dep_pair(mk(`OP_FP, 4'hE, 1'b1, 1'b0, 7'h10), m, 4);
    m = mk(`OP_LOAD, 4'h4, 1'b0, 1'b0, 7'h10);
    m.masked = 1'b1;
    dep_pair(mk(`OP_CMP, 4'hA, 1'b1, 1'b0, 7'h10), m, 4);
  endtask : t_mem_hazards

  task automatic t_arith_seq;
    int t0;
    clear_mon();
    issue(mk(`OP_FP, 4'h5, 1'b1, 1'b0, 7'h10), 1'b1);
    t0 = cyc;
    issue(mk(`OP_FP, 4'h6, 1'b1, 1'b0, 7'h10), 1'b0);
    check(cyc - t0 <= 2, 1'b1);
    drain();
    check(res_cnt[6], 4);
    check(first_cyc[6] > last_cyc[5], 1'b1);
    check(first_cyc[6] - last_cyc[5] == 2, 1'b1);
    issue(mk(`OP_FP, 4'h7, 1'b0, 1'b0, 7'h10), 1'b0);
    drain();
    check(last_cyc[7] - first_cyc[7], 6);
    issue(mk(`OP_DIV, 4'h8, 1'b1, 1'b0, 7'h10), 1'b1);
    issue(mk(`OP_FP, 4'h9, 1'b1, 1'b0, 7'h10), 1'b0);
    drain();
    check(first_cyc[9] - last_cyc[8] > 2, 1'b1);
  endtask : t_arith_seq

  task automatic t_fpu_route;
    for (int k = 0; k < 6; k++) begin
      issue(mk(4'(`OP_FP + k), 4'hB, 1'b1, 1'b0, 7'h10), 1'b0);
      @(negedge clk);
      check(fpu_active, k < 4);
      drain();
    end
  endtask : t_fpu_route

  initial begin
    err_total = 0;
    checked = 0;
    cyc = 0;
    rst_n = 1'b0;
    clear_mon();
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_reset_values();
    t_set_length();
    t_mem_ops();
    t_load_hazard();
    t_mem_hazards();
    t_arith_seq();
    t_fpu_route();
    wrap_up();
  end
endmodule : tb_vector_issue_scoreboard
